// ===== efr_pkg.sv
// constants, codes and state encodings for the feature read path
// assumes a single target on one bus, select code msb first
package efr_pkg;

  // select code layout
  localparam logic [3:0] FEAT_TYPE_CODE = 4'hB;
  localparam int         SEL_RW_BIT     = 0;
  localparam int         SEL_CE_LSB     = 1;
  localparam int         SEL_CE_MSB     = 3;
  localparam int         SEL_TYPE_LSB   = 4;
  localparam int         SEL_TYPE_MSB   = 7;
  localparam int         CE_BITS        = 3;

  // feature address space
  localparam logic [7:0] ADDR_HI_PAGE   = 8'h00;
  localparam logic [7:0] ADDR_HI_REG    = 8'h04;
  localparam logic [7:0] REG_LO_DEVTYPE = 8'h00;
  localparam logic [7:0] REG_LO_CE      = 8'h01;
  localparam logic [7:0] REG_LO_WP      = 8'h02;
  localparam logic [6:0] PAGE_LAST      = 7'h7F;
  localparam logic [6:0] PAGE_FIRST     = 7'h00;
  localparam logic [6:0] PAGE_STEP      = 7'h01;

  // delivery contents
  localparam logic [7:0] ERASED_BYTE    = 8'hFF;
  localparam logic [7:0] CE_REG_RESET   = 8'h00;
  localparam logic [7:0] WP_REG_RESET   = 8'h00;

  // bit counting
  localparam logic [2:0] BIT_FIRST      = 3'h0;
  localparam logic [2:0] BIT_SECOND     = 3'h1;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [2:0] BIT_STEP       = 3'h1;

  // configuration port selector
  localparam logic       CFG_SEL_CE     = 1'b0;
  localparam logic       CFG_SEL_WP     = 1'b1;

  typedef enum logic [2:0] {
    EFR_TGT_NONE    = 3'h0,
    EFR_TGT_PAGE    = 3'h1,
    EFR_TGT_DEVTYPE = 3'h2,
    EFR_TGT_CE      = 3'h3,
    EFR_TGT_WP      = 3'h4
  } efr_target_type;

  typedef enum logic [10:0] {
    EFR_IDLE     = 11'h001,
    EFR_DEVSEL   = 11'h002,
    EFR_ACK_SEL  = 11'h004,
    EFR_ADDR_HI  = 11'h008,
    EFR_ACK_HI   = 11'h010,
    EFR_ADDR_LO  = 11'h020,
    EFR_ACK_LO   = 11'h040,
    EFR_DATA_IN  = 11'h080,
    EFR_ACK_DATA = 11'h100,
    EFR_READ_OUT = 11'h200,
    EFR_ACK_RD   = 11'h400
  } efr_state_type;

endpackage

// ===== efr_sync.sv
// two flip-flop level synchroniser, one per bit
// assumes multi-bit words are quasi-static while sampled
`timescale 1ns/1ps
module efr_sync
  import efr_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_in,  // destination clock
  input  wire logic             rst_in,  // async reset, active high
  input  wire logic             en_in,   // clock enable
  input  wire logic [WIDTH-1:0] d_in,    // level from the other domain
  output logic      [WIDTH-1:0] q_out    // synchronised level
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta  <= '0;
      q_out <= '0;
    end else if (en_in) begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule

// ===== efr_evt.sv
// toggle-to-pulse event crossing
// assumes the source toggles no faster than every three destination cycles
`timescale 1ns/1ps
module efr_evt
  import efr_pkg::*;
(
  input  wire logic clk_in,    // destination clock
  input  wire logic rst_in,    // async reset, active high
  input  wire logic en_in,     // clock enable
  input  wire logic tgl_in,    // toggle from the source domain
  output logic      pulse_out  // one-cycle pulse per toggle
);

  logic tgl_sync;
  logic tgl_seen;

  efr_sync #(.WIDTH(1)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .en_in  (en_in),
    .d_in   (tgl_in),
    .q_out  (tgl_sync)
  );

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tgl_seen  <= 1'b0;
      pulse_out <= 1'b0;
    end else if (en_in) begin
      tgl_seen  <= tgl_sync;
      pulse_out <= tgl_sync ^ tgl_seen;
    end
  end

endmodule

// ===== efr_feature_read.sv
// i2c target read path for the feature space: type, chip-enable and
// write-protect registers, identification page and the lock-status query
// assumes scl_in is the bus clock, sda is open drain with an external pull-up
`timescale 1ns/1ps

module efr_feature_read
  import efr_pkg::*;
#(
  parameter logic [7:0] DEV_TYPE_VALUE = 8'h5A  // arbitrary identifier value
) (
  input  wire logic       clk_in,                  // system clock, 10 MHz
  input  wire logic       sys_rst_in,              // async reset, active high
  input  wire logic       clk_en_in,               // system clock enable
  input  wire logic       scl_in,                  // bus clock, link domain
  input  wire logic       sda_in,                  // bus data level
  output logic            sda_out,                 // data value when driven
  output logic            sda_oe_n_out,            // low while pulling data low
  input  wire logic       program_busy_in,         // internal program cycle running
  input  wire logic       page_locked_in,          // identification page locked
  input  wire logic       cfg_wr_in,               // load a configuration register
  input  wire logic       cfg_sel_in,              // 0 chip-enable, 1 write-protect
  input  wire logic [7:0] cfg_data_in,             // value to load
  output logic      [7:0] chip_enable_config_out,  // chip_enable_config_register
  output logic      [7:0] write_protect_out,       // array_write_protect_register
  output logic            frame_active_out,        // between start and stop
  output logic            read_end_out             // pulse: stream ended by no ack or busy
);

  // ---------------- system domain ----------------
  logic [7:0] chip_enable_config_register;
  logic [7:0] array_write_protect_register;
  logic       start_pulse;
  logic       stop_pulse;
  logic       read_end_pulse;

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chip_enable_config_register  <= CE_REG_RESET;
      array_write_protect_register <= WP_REG_RESET;
    end else if (clk_en_in && cfg_wr_in) begin
      if (cfg_sel_in == CFG_SEL_CE) begin
        chip_enable_config_register <= cfg_data_in;
      end else begin
        array_write_protect_register <= cfg_data_in;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chip_enable_config_out <= CE_REG_RESET;
      write_protect_out      <= WP_REG_RESET;
      frame_active_out       <= 1'b0;
      read_end_out           <= 1'b0;
    end else if (clk_en_in) begin
      chip_enable_config_out <= chip_enable_config_register;
      write_protect_out      <= array_write_protect_register;
      read_end_out           <= read_end_pulse;
      // a start quickly followed by a stop can land in one cycle; the stop is
      // the later event then, since a new start must wait out the bus free time
      if (stop_pulse) begin
        frame_active_out <= 1'b0;
      end else if (start_pulse) begin
        frame_active_out <= 1'b1;
      end
    end
  end

  // ---------------- start and stop detection ----------------
  // data falling with the clock high is a start, rising is a stop
  logic start_tgl;
  logic stop_tgl;

  always_ff @(negedge sda_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      start_tgl <= 1'b0;
    end else if (scl_in) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_ff @(posedge sda_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stop_tgl <= 1'b0;
    end else if (scl_in) begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // ---------------- link domain ----------------
  logic                 busy_s;
  logic                 locked_s;
  logic [7:0]           ce_reg_s;
  logic [7:0]           wp_reg_s;
  efr_state_type        state;
  efr_target_type       target;
  logic [2:0]           bit_cnt;
  logic [7:0]           rx_shift;
  logic [7:0]           tx_shift;
  logic [7:0]           addr_hi;
  logic [6:0]           page_addr;
  logic                 addr_valid;
  logic                 ack_ok;
  logic                 start_taken;
  logic                 read_end_tgl;
  logic                 start_pending;
  logic [7:0]           rx_byte;
  logic [7:0]           feature_byte;
  logic                 sel_match;
  efr_target_type       next_target;
  logic                 drive_low;

  efr_sync #(.WIDTH(2)) u_sync_flags (
    .clk_in (scl_in),
    .rst_in (sys_rst_in),
    .en_in  (1'b1),
    .d_in   ({program_busy_in, page_locked_in}),
    .q_out  ({busy_s, locked_s})
  );

  efr_sync #(.WIDTH(16)) u_sync_regs (
    .clk_in (scl_in),
    .rst_in (sys_rst_in),
    .en_in  (1'b1),
    .d_in   ({chip_enable_config_register, array_write_protect_register}),
    .q_out  ({ce_reg_s, wp_reg_s})
  );

  efr_evt u_evt_start (
    .clk_in    (clk_in),
    .rst_in    (sys_rst_in),
    .en_in     (clk_en_in),
    .tgl_in    (start_tgl),
    .pulse_out (start_pulse)
  );

  efr_evt u_evt_stop (
    .clk_in    (clk_in),
    .rst_in    (sys_rst_in),
    .en_in     (clk_en_in),
    .tgl_in    (stop_tgl),
    .pulse_out (stop_pulse)
  );

  efr_evt u_evt_end (
    .clk_in    (clk_in),
    .rst_in    (sys_rst_in),
    .en_in     (clk_en_in),
    .tgl_in    (read_end_tgl),
    .pulse_out (read_end_pulse)
  );

  // start toggle is settled by the bus hold time before the next clock rise
  assign start_pending = start_tgl ^ start_taken;
  assign rx_byte       = {rx_shift[6:0], sda_in};

  assign sel_match = (rx_byte[SEL_TYPE_MSB:SEL_TYPE_LSB] == FEAT_TYPE_CODE) &&
                     (rx_byte[SEL_CE_MSB:SEL_CE_LSB] == ce_reg_s[CE_BITS-1:0]);

  // byte served for the current target; page content is the erased value
  always_comb begin
    case (target)
      EFR_TGT_DEVTYPE: feature_byte = DEV_TYPE_VALUE;
      EFR_TGT_CE:      feature_byte = ce_reg_s;
      EFR_TGT_WP:      feature_byte = wp_reg_s;
      EFR_TGT_PAGE:    feature_byte = ERASED_BYTE;
      default:         feature_byte = ERASED_BYTE;
    endcase
  end

  always_comb begin
    next_target = EFR_TGT_NONE;
    if (addr_hi == ADDR_HI_PAGE) begin
      next_target = EFR_TGT_PAGE;
    end else if (addr_hi == ADDR_HI_REG) begin
      case (rx_byte)
        REG_LO_DEVTYPE: next_target = EFR_TGT_DEVTYPE;
        REG_LO_CE:      next_target = EFR_TGT_CE;
        REG_LO_WP:      next_target = EFR_TGT_WP;
        default:        next_target = EFR_TGT_NONE;
      endcase
    end
  end

  always_ff @(posedge scl_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      start_taken <= 1'b0;
    end else begin
      start_taken <= start_tgl;
    end
  end

  // protocol sequencer: bits are sampled on the rising clock edge
  always_ff @(posedge scl_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state        <= EFR_IDLE;
      target       <= EFR_TGT_NONE;
      bit_cnt      <= BIT_FIRST;
      rx_shift     <= '0;
      tx_shift     <= ERASED_BYTE;
      addr_hi      <= '0;
      page_addr    <= PAGE_FIRST;
      addr_valid   <= 1'b0;
      ack_ok       <= 1'b0;
      read_end_tgl <= 1'b0;
    end else if (start_pending) begin
      // any start abandons a pending truncated command
      state    <= EFR_DEVSEL;
      bit_cnt  <= BIT_SECOND;
      rx_shift <= rx_byte;
      ack_ok   <= 1'b0;
    end else begin
      case (state)
        EFR_DEVSEL, EFR_ADDR_HI, EFR_ADDR_LO, EFR_DATA_IN: begin
          rx_shift <= rx_byte;
          bit_cnt  <= bit_cnt + BIT_STEP;
          if (bit_cnt == BIT_LAST) begin
            bit_cnt <= BIT_FIRST;
            case (state)
              EFR_DEVSEL: begin
                state  <= EFR_ACK_SEL;
                // reads need a loaded address; busy refuses all
                ack_ok <= sel_match && !busy_s &&
                          (!rx_byte[SEL_RW_BIT] || addr_valid);
                if (rx_byte[SEL_RW_BIT]) begin
                  tx_shift <= feature_byte;
                end
              end
              EFR_ADDR_HI: begin
                state   <= EFR_ACK_HI;
                addr_hi <= rx_byte;
                ack_ok  <= !busy_s;
              end
              EFR_ADDR_LO: begin
                state      <= EFR_ACK_LO;
                target     <= next_target;
                page_addr  <= rx_byte[6:0];
                addr_valid <= (next_target != EFR_TGT_NONE);
                ack_ok     <= !busy_s;
              end
              default: begin
                state  <= EFR_ACK_DATA;
                // lock query: acknowledge reports unlocked
                ack_ok <= (target == EFR_TGT_PAGE) && !locked_s && !busy_s;
              end
            endcase
          end
        end
        EFR_ACK_SEL: begin
          if (!ack_ok) begin
            state <= EFR_IDLE;
          end else if (rx_shift[SEL_RW_BIT]) begin
            state <= EFR_READ_OUT;
          end else begin
            state <= EFR_ADDR_HI;
          end
        end
        EFR_ACK_HI: begin
          state <= ack_ok ? EFR_ADDR_LO : EFR_IDLE;
        end
        EFR_ACK_LO: begin
          state <= ack_ok ? EFR_DATA_IN : EFR_IDLE;
        end
        EFR_ACK_DATA: begin
          // truncated command is held, never executed
          state <= EFR_IDLE;
        end
        EFR_READ_OUT: begin
          tx_shift <= {tx_shift[6:0], 1'b0};
          bit_cnt  <= bit_cnt + BIT_STEP;
          if (bit_cnt == BIT_LAST) begin
            bit_cnt <= BIT_FIRST;
            state   <= EFR_ACK_RD;
            if (target == EFR_TGT_PAGE) begin
              // step after every page byte, wrap at the end
              page_addr <= (page_addr == PAGE_LAST) ? PAGE_FIRST : page_addr + PAGE_STEP;
            end
            // register targets keep the counter fixed
          end
        end
        EFR_ACK_RD: begin
          // controller acknowledge sampled in the ninth slot
          if (!sda_in && !busy_s) begin
            state    <= EFR_READ_OUT;
            tx_shift <= feature_byte;
          end else begin
            // no acknowledge or busy: stop driving and stand
            state        <= EFR_IDLE;
            read_end_tgl <= ~read_end_tgl;
          end
        end
        default: begin
          state <= EFR_IDLE;
        end
      endcase
    end
  end

  // data line is changed on the falling clock edge
  always_comb begin
    drive_low = 1'b0;
    case (state)
      EFR_ACK_SEL, EFR_ACK_HI, EFR_ACK_LO, EFR_ACK_DATA: drive_low = ack_ok;
      EFR_READ_OUT: drive_low = !tx_shift[7];
      default:      drive_low = 1'b0;
    endcase
    if (busy_s || start_pending) begin
      drive_low = 1'b0;
    end
  end

  always_ff @(negedge scl_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= !drive_low;
    end
  end

endmodule

// ===== efr_feature_read_assertions.sv
// checker for the feature read path: register copies and bus release
// assumes binding to efr_feature_read and sight of its ports only
`timescale 1ns/1ps
module efr_feature_read_checker
  import efr_pkg::*;
(
  input wire logic       clk_in,                  // clock
  input wire logic       sys_rst_in,              // reset
  input wire logic       clk_en_in,               // enable
  input wire logic       scl_in,                  // bus clock
  input wire logic       sda_in,                  // bus data
  input wire logic       sda_out,                 // data value
  input wire logic       sda_oe_n_out,            // drive low
  input wire logic       program_busy_in,         // busy
  input wire logic       page_locked_in,          // locked
  input wire logic       cfg_wr_in,               // load
  input wire logic       cfg_sel_in,              // target
  input wire logic [7:0] cfg_data_in,             // value
  input wire logic [7:0] chip_enable_config_out,  // ce copy
  input wire logic [7:0] write_protect_out,       // wp copy
  input wire logic       frame_active_out,        // in frame
  input wire logic       read_end_out             // end pulse
);
  logic wr_ce;
  logic wr_wp;
  assign wr_ce = cfg_wr_in & clk_en_in & (cfg_sel_in == CFG_SEL_CE);
  assign wr_wp = cfg_wr_in & clk_en_in & (cfg_sel_in == CFG_SEL_WP);

  rst_vals_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(sys_rst_in) |-> {chip_enable_config_out, write_protect_out} == {CE_REG_RESET, WP_REG_RESET})
    else $error("copies not clear after reset");
  ce_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_ce |-> ##2 chip_enable_config_out == $past(cfg_data_in, 2))
    else $error("ce copy wrong");
  wp_load_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    wr_wp |-> ##2 write_protect_out == $past(cfg_data_in, 2))
    else $error("wp copy wrong");
  ce_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(wr_ce, 2) |-> $stable(chip_enable_config_out))
    else $error("ce copy moved");
  wp_hold_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !$past(wr_wp, 2) |-> $stable(write_protect_out))
    else $error("wp copy moved");
  busy_rel_a: assert property (@(posedge scl_in) disable iff (sys_rst_in)
    program_busy_in [*4] |-> sda_oe_n_out)
    else $error("data driven while busy");
  read_end_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    read_end_out |-> sda_oe_n_out ##1 !read_end_out)
    else $error("bad stream end");
  stop_rel_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $fell(frame_active_out) |-> sda_oe_n_out)
    else $error("data driven after stop");
endmodule

bind efr_feature_read efr_feature_read_checker u_chk (
  .clk_in, .sys_rst_in, .clk_en_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out,
  .program_busy_in, .page_locked_in, .cfg_wr_in, .cfg_sel_in, .cfg_data_in,
  .chip_enable_config_out, .write_protect_out, .frame_active_out, .read_end_out
);

// ===== efr_i2c_ctrl_model.sv
// bus controller model: start, stop, byte write and byte read
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module efr_i2c_ctrl_model (
  output logic      scl_out,      // bus clock, idles high
  output logic      sda_low_out,  // high while pulling data low
  input  wire logic sda_in        // resolved data level
);
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // one 30 ns slot, data changed while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    #7;
    scl_out = 1'b1;
    #8;
    r = sda_in;
    #7;
    scl_out = 1'b0;
    #8;
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    #7;
    scl_out = 1'b1;
    #8;
    sda_low_out = 1'b1;
    #7;
    scl_out = 1'b0;
    #8;
  endtask
  // clock then stands still high
  task automatic stop();
    sda_low_out = 1'b1;
    #7;
    scl_out = 1'b1;
    #8;
    sda_low_out = 1'b0;
    #15;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask
endmodule

// ===== testbench.sv
// testbench for the feature read path against a bus controller model
// assumes a pulled-up data line; the model makes the 30 ns bus clock
`timescale 1ns/1ps
module testbench
  import efr_pkg::*;
;
  localparam logic [7:0] TYPE_V = 8'hC3;  // arbitrary identifier value
  logic       clk_in;
  logic       sys_rst_in;
  logic       clk_en_in;
  logic       scl_in;
  logic       sda_in;
  logic       sda_low;
  logic       sda_out;
  logic       sda_oe_n_out;
  logic       program_busy_in;
  logic       page_locked_in;
  logic       cfg_wr_in;
  logic       cfg_sel_in;
  logic [7:0] cfg_data_in;
  logic [7:0] chip_enable_config_out;
  logic [7:0] write_protect_out;
  logic       frame_active_out;
  logic       read_end_out;
  int         mismatches;
  int         cmp_count;

  assign sda_in = ~sda_low & (sda_oe_n_out | sda_out);

  efr_feature_read #(.DEV_TYPE_VALUE(TYPE_V)) u_efr_feature_read (
    .clk_in, .sys_rst_in, .clk_en_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out,
    .program_busy_in, .page_locked_in, .cfg_wr_in, .cfg_sel_in, .cfg_data_in,
    .chip_enable_config_out, .write_protect_out, .frame_active_out, .read_end_out
  );
  efr_i2c_ctrl_model u_ctrl (.scl_out(scl_in), .sda_low_out(sda_low), .sda_in);

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fin(input logic re);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk_in);
      seen = seen | (read_end_out === 1'b1);
    end
    chk("read_end", {7'h0, re}, {7'h0, seen});
    chk("frame", 8'h00, {7'h0, frame_active_out});
  endtask
  task automatic wr(input logic [7:0] b, input logic e);
    logic a;
    u_ctrl.wbyte(b, a);
    chk("ack", {7'h0, e}, {7'h0, a});
  endtask
  task automatic addr(input logic [2:0] ce, input logic [7:0] hi, lo);
    u_ctrl.start();
    wr({FEAT_TYPE_CODE, ce, 1'b0}, 1'b1);
    wr(hi, 1'b1);
    wr(lo, 1'b1);
  endtask
  task automatic refuse(input logic [2:0] ce, input logic rw);
    u_ctrl.start();
    wr({FEAT_TYPE_CODE, ce, rw}, 1'b0);
    u_ctrl.stop();
    fin(1'b0);
  endtask
  task automatic rd(input logic [2:0] ce, input logic [7:0] hi, lo, e, input int n);
    logic [7:0] d;
    addr(ce, hi, lo);
    u_ctrl.start();
    wr({FEAT_TYPE_CODE, ce, 1'b1}, 1'b1);
    chk("frame_on", 8'h01, {7'h0, frame_active_out});
    for (int i = 0; i < n; i++) begin
      u_ctrl.rbyte(i == n - 1, d);
      chk("byte", e, d);
    end
    u_ctrl.stop();
    fin(1'b1);
  endtask
  task automatic cfg(input logic s, input logic [7:0] d, input logic en);
    @(negedge clk_in);
    clk_en_in = en;
    cfg_wr_in = 1'b1;
    cfg_sel_in = s;
    cfg_data_in = d;
    @(negedge clk_in);
    cfg_wr_in = 1'b0;
    clk_en_in = 1'b1;
    repeat (3) @(negedge clk_in);
  endtask

  task automatic t_reads();
    chk("ce_out", CE_REG_RESET, chip_enable_config_out);
    chk("wp_out", WP_REG_RESET, write_protect_out);
    refuse(3'h0, 1'b1);
    rd(3'h0, ADDR_HI_REG, REG_LO_DEVTYPE, TYPE_V, 3);
    rd(3'h0, ADDR_HI_PAGE, 8'h7E, ERASED_BYTE, 4);
    $display("t_reads done");
  endtask
  task automatic t_ce();
    cfg(CFG_SEL_CE, 8'h05, 1'b0);
    chk("ce_held", 8'h00, chip_enable_config_out);
    cfg(CFG_SEL_CE, 8'h05, 1'b1);
    chk("ce_out", 8'h05, chip_enable_config_out);
    refuse(3'h0, 1'b0);
    rd(3'h5, ADDR_HI_REG, REG_LO_CE, 8'h05, 3);
    chk("ce_keep", 8'h05, chip_enable_config_out);
    cfg(CFG_SEL_CE, 8'h00, 1'b1);
    $display("t_ce done");
  endtask
  task automatic t_wp();
    cfg(CFG_SEL_WP, 8'hA5, 1'b1);
    rd(3'h0, ADDR_HI_REG, REG_LO_WP, 8'hA5, 3);
    chk("wp_keep", 8'hA5, write_protect_out);
    addr(3'h0, ADDR_HI_REG, 8'h07);
    refuse(3'h0, 1'b1);
    $display("t_wp done");
  endtask
  task automatic t_lock();
    for (int k = 0; k < 2; k++) begin
      page_locked_in = k[0];
      addr(3'h0, ADDR_HI_PAGE, 8'h10);
      wr(8'h02, ~k[0]);
      u_ctrl.start();
      u_ctrl.stop();
      fin(1'b0);
    end
    page_locked_in = 1'b0;
    $display("t_lock done");
  endtask
  task automatic t_busy();
    program_busy_in = 1'b1;
    refuse(3'h0, 1'b0);
    program_busy_in = 1'b0;
    for (int k = 0; k < 3; k++) begin
      addr(3'h0, ADDR_HI_REG, 8'(k));
      @(negedge clk_in);
      program_busy_in = 1'b1;
      refuse(3'h0, 1'b1);
      program_busy_in = 1'b0;
    end
    $display("t_busy done");
  endtask

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    clk_en_in = 1'b1;
    program_busy_in = 1'b0;
    page_locked_in = 1'b0;
    cfg_wr_in = 1'b0;
    cfg_sel_in = 1'b0;
    cfg_data_in = 8'h00;
    mismatches = 0;
    cmp_count = 0;
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    t_reads();
    t_ce();
    t_wp();
    t_lock();
    t_busy();
    close_out();
  end
endmodule
